// >>> include/pms_pkg.sv
// package: constants, register map and types for the power module sequencer
package pms_pkg;
   // clocking and timing
   localparam int CLK_PERIOD_NS  = 4;
   localparam int MS_NS          = 1000000;
   localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
   localparam int INIT_MS        = 2;
   localparam int LINK_PERIOD_NS = 125;
   localparam int SYNC_NOM_CYC   = LINK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SYNC_DRIFT_PCT = 10;
   localparam int SYNC_LO_CYC    = SYNC_NOM_CYC * (100 - SYNC_DRIFT_PCT) / 100;
   localparam int SYNC_HI_CYC    = (SYNC_NOM_CYC * (100 + SYNC_DRIFT_PCT) + 99) / 100;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL      = 12'h000;
   localparam logic [11:0] OFS_VOUT_CMD  = 12'h004;
   localparam logic [11:0] OFS_VOUT_MAX  = 12'h008;
   localparam logic [11:0] OFS_TON_DELAY = 12'h00C;
   localparam logic [11:0] OFS_TON_RISE  = 12'h010;
   localparam logic [11:0] OFS_PG_ON     = 12'h014;
   localparam logic [11:0] OFS_PG_DELAY  = 12'h018;
   localparam logic [11:0] OFS_STATUS    = 12'h01C;
   localparam logic [11:0] OFS_IRQ_STAT  = 12'h020;
   localparam logic [11:0] OFS_IRQ_CLR   = 12'h024;
   localparam logic [11:0] OFS_IRQ_EN    = 12'h028;
   // field positions
   localparam int CTRL_ON_BIT    = 0;
   localparam int CTRL_EXT_BIT   = 1;
   localparam int PGON_UNDER_LSB = 0;
   localparam int PGON_OVER_LSB  = 8;
   localparam int PGON_POL_BIT   = 16;
   localparam int IRQ_PG_ON      = 0;
   localparam int IRQ_PG_OFF     = 1;
   localparam int IRQ_SYNC_LOST  = 2;
   localparam int IRQ_RAMP_DONE  = 3;
   localparam int IRQ_W          = 4;
   // limits and reset values, voltages in millivolts, times in milliseconds
   localparam logic [15:0] VOUT_MIN_MV   = 16'h0258;
   localparam logic [15:0] VOUT_TOP_MV   = 16'h05DC;
   localparam logic [15:0] VMAX_LIMIT_MV = 16'h07D0;
   localparam logic [15:0] VMAX_DIV      = 16'h000A;
   localparam logic [15:0] TON_DELAY_RST = 16'h0005;
   localparam logic [15:0] TON_RISE_RST  = 16'h0005;
   localparam logic [15:0] PG_DELAY_RST  = 16'h0001;
   localparam logic [7:0]  PG_PCT_RST    = 8'h0A;
   localparam logic [4:0]  STRAP_GND     = 5'h08;
   localparam logic [4:0]  STRAP_OPEN    = 5'h0C;

   typedef enum logic [3:0] {
      ST_OFF   = 4'h1,
      ST_DELAY = 4'h2,
      ST_RISE  = 4'h4,
      ST_ON    = 4'h8
   } seq_state_t;

   typedef struct packed {
      logic [15:0] vout_cmd;
      logic [15:0] vout_max;
      logic [15:0] ton_delay;
      logic [15:0] ton_rise;
      logic [15:0] pg_delay;
      logic [7:0]  pg_under;
      logic [7:0]  pg_over;
      logic        pg_active_high;
      logic        on_cmd;
      logic        ext_sync_sel;
   } cfg_t;

   // strap code to output target; codes above the table read as open
   function automatic logic [15:0] strap_mv(input logic [4:0] code);
      case (code)
         5'h00: strap_mv = 16'h0258;
         5'h01: strap_mv = 16'h028A;
         5'h02: strap_mv = 16'h02BC;
         5'h03: strap_mv = 16'h02EE;
         5'h04: strap_mv = 16'h0320;
         5'h05: strap_mv = 16'h0352;
         5'h06: strap_mv = 16'h0384;
         5'h07: strap_mv = 16'h03B6;
         5'h08: strap_mv = 16'h03E8;
         5'h09: strap_mv = 16'h041A;
         5'h0A: strap_mv = 16'h044C;
         5'h0B: strap_mv = 16'h047E;
         5'h0D: strap_mv = 16'h04E2;
         5'h0E: strap_mv = 16'h0514;
         5'h0F: strap_mv = 16'h0578;
         5'h10: strap_mv = 16'h05DC;
         default: strap_mv = 16'h04B0;
      endcase
   endfunction
endpackage

// >>> src/ms_timer.sv
// millisecond interval timer: counts ticks while running, flags when limit reached
`timescale 1ns/1ps
module ms_timer #(
   parameter int W = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         reset_n_i,
   input  wire logic         tick_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] limit_i,
   output logic              done_o
);
   logic [W-1:0] cnt_ff;

   // count restarts from zero whenever run drops; saturates at the limit
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_ff <= '0;
      end else if (!run_i) begin
         cnt_ff <= '0;
      end else if (tick_i && (cnt_ff < limit_i)) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign done_o = run_i && (cnt_ff >= limit_i);
endmodule

// >>> src/power_module_sequencer.sv
// power module sequencer: apb registers, turn-on sequence, power-good and sync lock
//
// Notes on behaviour
// - configuration and monitoring come through the management register interface.
// - only the start-up target and the ceiling default use straps; every other setting is writable.
// - start-up target from the strap, seventeen levels; open 1.20 V, ground 1.00 V.
// - output target command accepts 0.6 V to 1.5 V, replacing the strap value.
// - ceiling defaults to 110% of strap target, programmable up to 2 V.
// - turn-on delay starts at enable assertion and ends when it expires.
// - turn-on delay and ramp time are independent settings.
// - zero delay starts the ramp once the 2 ms initialisation completes.
// - zero ramp time means no timed ramp, output rises at once.
// - power-good only while output is in tolerance and no fault.
// - default tolerance window is 10% around the target.
// - power-good limits and output polarity are programmable.
// - power-good waits a programmable delay after all conditions hold.
// - external switching clock stays locked within plus or minus 10% drift.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module power_module_sequencer #(
   parameter int MS_CYCLES = pms_pkg::MS_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        enable_i,
   input  wire logic [4:0]  voltage_strap_pin_i,
   input  wire logic        ext_sync_i,
   input  wire logic [15:0] vout_meas_i,
   input  wire logic        fault_i,
   output logic [15:0]      vout_target_o,
   output logic             drive_en_o,
   output logic             ramp_active_o,
   output logic             use_ext_clk_o,
   output logic             sync_locked_o,
   output logic             power_good_output_o,
   output logic             irq_o
);
   localparam int TW = $clog2(MS_CYCLES);
   // edges after reset release before the strap has passed both flip-flops
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   pms_pkg::cfg_t          cfg_ff;
   pms_pkg::seq_state_t    state_ff;
   pms_pkg::seq_state_t    nxt_state;
   logic [TW-1:0]          div_ff;
   logic                   tick;
   logic [1:0]             en_sync_ff;
   logic [4:0]             strap_s1_ff;
   logic [4:0]             strap_s2_ff;
   logic                   strap_done_ff;
   logic [1:0]             strap_wait_ff;
   logic [2:0]             sync_sh_ff;
   logic [7:0]             per_ff;
   logic                   locked_ff;
   logic                   sync_edge;
   logic                   on_req;
   logic                   init_done;
   logic                   delay_done;
   logic                   rise_done;
   logic                   pg_done;
   logic                   pg_cond;
   logic                   in_window;
   logic                   pg_int_ff;
   logic [15:0]            tgt;
   logic [23:0]            err_x100;
   logic [23:0]            tol_under;
   logic [23:0]            tol_over;
   logic [pms_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [pms_pkg::IRQ_W-1:0] irq_en_ff;
   logic [pms_pkg::IRQ_W-1:0] irq_set;
   logic                   wr_en;
   logic                   mapped;
   logic [15:0]            wdata16;
   logic [31:0]            nxt_rdata;

   // millisecond tick from the core clock
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_ff <= '0;
      end else if (tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end
   assign tick = (div_ff == TW'(MS_CYCLES - 1));

   // pin synchronisers for enable and strap
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_sync_ff  <= 2'h0;
         strap_s1_ff <= 5'h00;
         strap_s2_ff <= 5'h00;
         strap_wait_ff <= 2'h0;
      end else begin
         en_sync_ff  <= {en_sync_ff[0], enable_i};
         strap_s1_ff <= voltage_strap_pin_i;
         strap_s2_ff <= strap_s1_ff;
         // hold off the capture until the second flop holds a real pin sample
         if (strap_wait_ff != STRAP_SETTLE) strap_wait_ff <= strap_wait_ff + 2'h1;
      end
   end

   // enable pin or bus on-command starts a turn-on
   assign on_req = en_sync_ff[1] | cfg_ff.on_cmd;

   // apb decode; zero wait states
   assign wr_en   = psel && penable && pwrite;
   assign wdata16 = pwdata[15:0];
   assign pready  = 1'b1;
   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         pms_pkg::OFS_CTRL, pms_pkg::OFS_VOUT_CMD, pms_pkg::OFS_VOUT_MAX,
         pms_pkg::OFS_TON_DELAY, pms_pkg::OFS_TON_RISE, pms_pkg::OFS_PG_ON,
         pms_pkg::OFS_PG_DELAY, pms_pkg::OFS_STATUS, pms_pkg::OFS_IRQ_STAT,
         pms_pkg::OFS_IRQ_CLR, pms_pkg::OFS_IRQ_EN: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // configuration registers; strap sets the start-up target
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_ff.vout_cmd       <= pms_pkg::VOUT_MIN_MV;
         cfg_ff.vout_max       <= pms_pkg::VMAX_LIMIT_MV;
         cfg_ff.ton_delay      <= pms_pkg::TON_DELAY_RST;
         cfg_ff.ton_rise       <= pms_pkg::TON_RISE_RST;
         cfg_ff.pg_delay       <= pms_pkg::PG_DELAY_RST;
         cfg_ff.pg_under       <= pms_pkg::PG_PCT_RST;
         cfg_ff.pg_over        <= pms_pkg::PG_PCT_RST;
         cfg_ff.pg_active_high <= 1'b1;
         cfg_ff.on_cmd         <= 1'b0;
         cfg_ff.ext_sync_sel   <= 1'b0;
         strap_done_ff         <= 1'b0;
      end else if (!strap_done_ff && (strap_wait_ff == STRAP_SETTLE)) begin
         // strap caught once after reset release
         strap_done_ff    <= 1'b1;
         cfg_ff.vout_cmd  <= pms_pkg::strap_mv(strap_s2_ff);
         cfg_ff.vout_max  <= pms_pkg::strap_mv(strap_s2_ff)
                             + pms_pkg::strap_mv(strap_s2_ff) / pms_pkg::VMAX_DIV;
      end else if (wr_en) begin
         unique case (paddr)
            pms_pkg::OFS_CTRL: begin
               cfg_ff.on_cmd       <= pwdata[pms_pkg::CTRL_ON_BIT];
               cfg_ff.ext_sync_sel <= pwdata[pms_pkg::CTRL_EXT_BIT];
            end
            pms_pkg::OFS_VOUT_CMD: begin
               // clamp into the allowed target range
               if (wdata16 < pms_pkg::VOUT_MIN_MV) begin
                  cfg_ff.vout_cmd <= pms_pkg::VOUT_MIN_MV;
               end else if (wdata16 > pms_pkg::VOUT_TOP_MV) begin
                  cfg_ff.vout_cmd <= pms_pkg::VOUT_TOP_MV;
               end else begin
                  cfg_ff.vout_cmd <= wdata16;
               end
            end
            pms_pkg::OFS_VOUT_MAX: begin
               cfg_ff.vout_max <= (wdata16 > pms_pkg::VMAX_LIMIT_MV) ?
                                  pms_pkg::VMAX_LIMIT_MV : wdata16;
            end
            pms_pkg::OFS_TON_DELAY: cfg_ff.ton_delay <= wdata16;
            pms_pkg::OFS_TON_RISE:  cfg_ff.ton_rise  <= wdata16;
            pms_pkg::OFS_PG_ON: begin
               cfg_ff.pg_under       <= pwdata[pms_pkg::PGON_UNDER_LSB +: 8];
               cfg_ff.pg_over        <= pwdata[pms_pkg::PGON_OVER_LSB +: 8];
               cfg_ff.pg_active_high <= pwdata[pms_pkg::PGON_POL_BIT];
            end
            pms_pkg::OFS_PG_DELAY: cfg_ff.pg_delay <= wdata16;
            default: ;
         endcase
      end
   end

   // read data captured in the setup cycle
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (paddr)
         pms_pkg::OFS_CTRL:      nxt_rdata = {30'h0, cfg_ff.ext_sync_sel, cfg_ff.on_cmd};
         pms_pkg::OFS_VOUT_CMD:  nxt_rdata = {16'h0000, cfg_ff.vout_cmd};
         pms_pkg::OFS_VOUT_MAX:  nxt_rdata = {16'h0000, cfg_ff.vout_max};
         pms_pkg::OFS_TON_DELAY: nxt_rdata = {16'h0000, cfg_ff.ton_delay};
         pms_pkg::OFS_TON_RISE:  nxt_rdata = {16'h0000, cfg_ff.ton_rise};
         pms_pkg::OFS_PG_ON:     nxt_rdata = {15'h0000, cfg_ff.pg_active_high,
                                              cfg_ff.pg_over, cfg_ff.pg_under};
         pms_pkg::OFS_PG_DELAY:  nxt_rdata = {16'h0000, cfg_ff.pg_delay};
         pms_pkg::OFS_STATUS:    nxt_rdata = {24'h000000, en_sync_ff[1], init_done,
                                              locked_ff, pg_int_ff, state_ff};
         pms_pkg::OFS_IRQ_STAT:  nxt_rdata = {28'h0000000, irq_stat_ff};
         pms_pkg::OFS_IRQ_EN:    nxt_rdata = {28'h0000000, irq_en_ff};
         default:                nxt_rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= nxt_rdata;
      end
   end

   // interval timers: init, turn-on delay, ramp, power-good delay
   ms_timer #(.W(16)) u_init (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .tick_i(tick), .run_i(1'b1), .limit_i(16'(pms_pkg::INIT_MS)), .done_o(init_done));
   ms_timer #(.W(16)) u_delay (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .tick_i(tick), .run_i(state_ff == pms_pkg::ST_DELAY), .limit_i(cfg_ff.ton_delay),
      .done_o(delay_done));
   ms_timer #(.W(16)) u_rise (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .tick_i(tick), .run_i(state_ff == pms_pkg::ST_RISE), .limit_i(cfg_ff.ton_rise),
      .done_o(rise_done));
   ms_timer #(.W(16)) u_pgdly (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .tick_i(tick), .run_i(pg_cond), .limit_i(cfg_ff.pg_delay), .done_o(pg_done));

   // turn-on sequence; dropping the request returns to off
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         pms_pkg::ST_OFF:   if (on_req) nxt_state = pms_pkg::ST_DELAY;
         pms_pkg::ST_DELAY: begin
            // zero delay waits only for initialisation
            if (cfg_ff.ton_delay == 16'h0000 ? init_done : (delay_done && init_done))
               nxt_state = pms_pkg::ST_RISE;
         end
         pms_pkg::ST_RISE:  if (rise_done) nxt_state = pms_pkg::ST_ON;
         pms_pkg::ST_ON:    nxt_state = pms_pkg::ST_ON;
         default:           nxt_state = pms_pkg::ST_OFF;
      endcase
      if (!on_req) nxt_state = pms_pkg::ST_OFF;
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= pms_pkg::ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // target is the command capped by the ceiling
   assign tgt = (cfg_ff.vout_cmd > cfg_ff.vout_max) ? cfg_ff.vout_max : cfg_ff.vout_cmd;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         vout_target_o <= 16'h0000;
         drive_en_o    <= 1'b0;
         ramp_active_o <= 1'b0;
      end else begin
         vout_target_o <= tgt;
         drive_en_o    <= (nxt_state == pms_pkg::ST_RISE) || (nxt_state == pms_pkg::ST_ON);
         ramp_active_o <= (nxt_state == pms_pkg::ST_RISE);
      end
   end

   // tolerance window in percent of target
   assign err_x100  = (vout_meas_i >= tgt) ? 24'(vout_meas_i - tgt) * 24'h000064
                                           : 24'(tgt - vout_meas_i) * 24'h000064;
   assign tol_under = 24'(tgt) * 24'(cfg_ff.pg_under);
   assign tol_over  = 24'(tgt) * 24'(cfg_ff.pg_over);
   assign in_window = (vout_meas_i >= tgt) ? (err_x100 <= tol_over) : (err_x100 <= tol_under);
   assign pg_cond   = (state_ff == pms_pkg::ST_ON) && !fault_i && in_window;

   // power-good after delay; lapse restarts the delay timer
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pg_int_ff <= 1'b0;
      end else begin
         pg_int_ff <= pg_cond && pg_done;
      end
   end
   assign power_good_output_o = cfg_ff.pg_active_high ? pg_int_ff : !pg_int_ff;

   // external clock: edge detect, period measure, lock within drift window
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync_sh_ff <= 3'h0;
         per_ff     <= 8'h00;
         locked_ff  <= 1'b0;
      end else begin
         sync_sh_ff <= {sync_sh_ff[1:0], ext_sync_i};
         if (sync_edge) begin
            per_ff    <= 8'h01;
            locked_ff <= (per_ff >= 8'(pms_pkg::SYNC_LO_CYC)) &&
                         (per_ff <= 8'(pms_pkg::SYNC_HI_CYC));
         end else if (per_ff != 8'hFF) begin
            per_ff <= per_ff + 8'h01;
         end
         if (!sync_edge && per_ff > 8'(pms_pkg::SYNC_HI_CYC)) locked_ff <= 1'b0;
      end
   end
   assign sync_edge     = sync_sh_ff[1] && !sync_sh_ff[2];
   assign sync_locked_o = locked_ff;
   assign use_ext_clk_o = cfg_ff.ext_sync_sel && locked_ff;

   // sticky interrupt status; a set in the clearing cycle wins
   assign irq_set[pms_pkg::IRQ_PG_ON]     = (pg_cond && pg_done) && !pg_int_ff;
   assign irq_set[pms_pkg::IRQ_PG_OFF]    = pg_int_ff && !(pg_cond && pg_done);
   assign irq_set[pms_pkg::IRQ_SYNC_LOST] = cfg_ff.ext_sync_sel && locked_ff &&
      ((sync_edge && !((per_ff >= 8'(pms_pkg::SYNC_LO_CYC)) &&
                       (per_ff <= 8'(pms_pkg::SYNC_HI_CYC)))) ||
       (!sync_edge && per_ff > 8'(pms_pkg::SYNC_HI_CYC)));
   assign irq_set[pms_pkg::IRQ_RAMP_DONE] = (state_ff == pms_pkg::ST_RISE) &&
                                            (nxt_state == pms_pkg::ST_ON);
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_stat_ff <= '0;
         irq_en_ff   <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~((wr_en && paddr == pms_pkg::OFS_IRQ_CLR) ?
                        pwdata[pms_pkg::IRQ_W-1:0] : '0)) | irq_set;
         if (wr_en && paddr == pms_pkg::OFS_IRQ_EN) irq_en_ff <= pwdata[pms_pkg::IRQ_W-1:0];
      end
   end
   assign irq_o = |(irq_stat_ff & irq_en_ff);

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_pg_cond;
      pg_int_ff |-> $past(pg_cond);
   endproperty
   a_pg_cond: assert property (p_pg_cond) else $error("power-good without its conditions");

   property p_pg_delay;
      $rose(pg_int_ff) |-> $past(pg_done) && $past(state_ff == pms_pkg::ST_ON);
   endproperty
   a_pg_delay: assert property (p_pg_delay) else $error("power-good before delay expiry");

   property p_pg_lapse;
      !pg_cond |=> !pg_int_ff ##1 (!pg_int_ff || $past(cfg_ff.pg_delay) == 16'h0000);
   endproperty
   a_pg_lapse: assert property (p_pg_lapse) else $error("power-good kept after lapse");

   property p_pg_pol;
      !cfg_ff.pg_active_high |-> power_good_output_o == !pg_int_ff;
   endproperty
   a_pg_pol: assert property (p_pg_pol) else $error("power-good polarity wrong");

   property p_en_start;
      state_ff == pms_pkg::ST_OFF && on_req |=> state_ff == pms_pkg::ST_DELAY;
   endproperty
   a_en_start: assert property (p_en_start) else $error("delay did not start on enable");

   property p_zero_rise;
      state_ff == pms_pkg::ST_RISE && cfg_ff.ton_rise == 16'h0000 && on_req
         |=> state_ff == pms_pkg::ST_ON;
   endproperty
   a_zero_rise: assert property (p_zero_rise) else $error("zero ramp not immediate");

   property p_init_wait;
      state_ff == pms_pkg::ST_DELAY && !init_done |=> state_ff != pms_pkg::ST_RISE;
   endproperty
   a_init_wait: assert property (p_init_wait) else $error("ramp before initialisation");

   property p_tgt_range;
      strap_done_ff && cfg_ff.vout_max >= pms_pkg::VOUT_MIN_MV
         |-> tgt >= pms_pkg::VOUT_MIN_MV && tgt <= pms_pkg::VOUT_TOP_MV
                        && tgt <= cfg_ff.vout_max;
   endproperty
   a_tgt_range: assert property (p_tgt_range) else $error("target out of range");

   property p_strap;
      $rose(strap_done_ff) |-> cfg_ff.vout_cmd == pms_pkg::strap_mv($past(strap_s2_ff));
   endproperty
   a_strap: assert property (p_strap) else $error("strap target not applied");

   property p_lock;
      $rose(locked_ff) |-> $past(sync_edge) && $past(per_ff) >= 8'(pms_pkg::SYNC_LO_CYC);
   endproperty
   a_lock: assert property (p_lock) else $error("lock outside drift window");

   c_pg_up:   cover property ($rose(pg_int_ff));
   c_ramp:    cover property (state_ff == pms_pkg::ST_RISE ##1 state_ff == pms_pkg::ST_ON);
   c_lock:    cover property ($rose(locked_ff));
   c_irq:     cover property ($rose(irq_o));
endmodule

// >>> bench/pms_load_model.sv
// behavioural power stage and external switching clock
`timescale 1ns/1ps
module pms_load_model (
   input  wire logic        drive_en_i,
   input  wire logic [15:0] target_i,
   output logic [15:0]      vout_meas_o,
   output logic             ext_sync_o
);
   // output sits on target while the stage runs, collapses when off
   assign vout_meas_o = drive_en_i ? target_i : 16'h0000;
   // free-running sync clock, 125 ns period
   initial ext_sync_o = 1'b0;
   always #62.5 ext_sync_o = ~ext_sync_o;
endmodule

// >>> bench/power_module_sequencer_tb.sv
// self-checking bench for the power module sequencer
`timescale 1ns/1ps
module power_module_sequencer_tb;
   logic        core_clk_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, fault_i = 1'b0, pready, pslverr, irq_o, pg, drv, lck, sync;
   logic        en = 1'b0, ramp, uxc; // enable pin grounded while the bus has control
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] meas, tgt, v;
   logic [32:0] exp_q[$];
   int          fails = 0, n_checks = 0, seed = 32'hAB20;

   power_module_sequencer #(.MS_CYCLES(8)) uut (.core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enable_i(en), .voltage_strap_pin_i(pms_pkg::STRAP_GND), .ext_sync_i(sync),
      .vout_meas_i(meas), .fault_i(fault_i), .vout_target_o(tgt), .drive_en_o(drv),
      .ramp_active_o(ramp), .use_ext_clk_o(uxc), .sync_locked_o(lck),
      .power_good_output_o(pg), .irq_o(irq_o));
   pms_load_model far (.drive_en_i(drv), .target_i(tgt), .vout_meas_o(meas),
      .ext_sync_o(sync));

   always #2 core_clk_i = ~core_clk_i;

   task automatic end_sim;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge core_clk_i);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         chk(33'h0, 33'h1);
         end_sim;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // bounded wait for a flag level, then confirm it
   task automatic wait_for(ref logic s, input logic val);
      for (int n = 0; n < 400 && s !== val; n++) @(posedge core_clk_i) #1;
      chk({32'h0, s}, {32'h0, val});
      if (s !== val) end_sim;
   endtask

   // read results: {pslverr, prdata} against the oldest note
   always @(posedge core_clk_i) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, exp_q.pop_front());
   end

   initial begin
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rd(pms_pkg::OFS_VOUT_CMD, 33'h3E8);
      rd(pms_pkg::OFS_VOUT_MAX, 33'h44C);
      rd(pms_pkg::OFS_TON_DELAY, 33'h5);
      rd(pms_pkg::OFS_TON_RISE, 33'h5);
      rd(pms_pkg::OFS_PG_ON, 33'h1_0A0A);
      rd(pms_pkg::OFS_PG_DELAY, 33'h1);
      rd(12'h03C, 33'h1_0000_0000);
      apb(1'b1, pms_pkg::OFS_VOUT_CMD, 32'h100);
      rd(pms_pkg::OFS_VOUT_CMD, 33'h258);
      v = 16'(600 + $unsigned($random(seed)) % 901);
      apb(1'b1, pms_pkg::OFS_VOUT_CMD, {16'h0, v});
      rd(pms_pkg::OFS_VOUT_CMD, {17'h0, v});
      apb(1'b1, pms_pkg::OFS_VOUT_MAX, 32'hFFFF);
      rd(pms_pkg::OFS_VOUT_MAX, 33'h7D0);
      apb(1'b1, pms_pkg::OFS_IRQ_EN, 32'hF);
      apb(1'b1, pms_pkg::OFS_TON_DELAY, 32'h0);
      apb(1'b1, pms_pkg::OFS_TON_RISE, 32'h0);
      apb(1'b1, pms_pkg::OFS_PG_DELAY, 32'h3);
      apb(1'b1, pms_pkg::OFS_CTRL, 32'h3);
      wait_for(drv, 1'b1);
      wait_for(pg, 1'b1);
      chk({17'h0, tgt}, {17'h0, v});
      wait_for(irq_o, 1'b1);
      wait_for(lck, 1'b1);
      chk({32'h0, uxc}, 33'h1);
      @(posedge core_clk_i) fault_i <= 1'b1;
      wait_for(pg, 1'b0);
      @(posedge core_clk_i) fault_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      fault_i <= 1'b1;
      @(posedge core_clk_i);
      fault_i <= 1'b0;
      repeat (12) @(posedge core_clk_i) #1;
      chk({32'h0, pg}, 33'h0);
      wait_for(pg, 1'b1);
      apb(1'b1, pms_pkg::OFS_PG_ON, 32'h0A0A);
      wait_for(pg, 1'b0);
      apb(1'b1, pms_pkg::OFS_IRQ_EN, 32'h0);
      wait_for(irq_o, 1'b0);
      apb(1'b1, pms_pkg::OFS_IRQ_CLR, 32'hF);
      apb(1'b1, pms_pkg::OFS_IRQ_EN, 32'hF);
      wait_for(irq_o, 1'b0);
      apb(1'b1, pms_pkg::OFS_CTRL, 32'h0);
      wait_for(drv, 1'b0);
      // pin-started turn-on with a real delay and a ramp above half a millisecond
      apb(1'b1, pms_pkg::OFS_TON_DELAY, 32'h2);
      apb(1'b1, pms_pkg::OFS_TON_RISE, 32'h1);
      @(posedge core_clk_i) en <= 1'b1;
      repeat (6) @(posedge core_clk_i) #1;
      chk({32'h0, drv}, 33'h0);
      wait_for(ramp, 1'b1);
      wait_for(ramp, 1'b0);
      chk({32'h0, drv}, 33'h1);
      @(posedge core_clk_i) en <= 1'b0;
      wait_for(drv, 1'b0);
      end_sim;
   end
endmodule
